//--- core/serial_regs_pkg.sv
// shared constants and carrier types for the dual serial controller register bank
package serial_regs_pkg;

    // byte offsets on the register bus, one aligned word each
    localparam logic [7:0] OFS_LINE_STATUS_A = 8'h00;
    localparam logic [7:0] OFS_LINE_STATUS_B = 8'h04;
    localparam logic [7:0] OFS_OUT_PIN_CFG = 8'h08;
    localparam logic [7:0] OFS_AUX_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_INPUT_CHANGE = 8'h10;
    localparam logic [7:0] OFS_INT_PENDING = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;
    localparam logic [7:0] OFS_CT_PRESET_HIGH = 8'h1C;
    localparam logic [7:0] OFS_CT_PRESET_LOW = 8'h20;
    localparam logic [7:0] OFS_INT_VECTOR = 8'h24;
    localparam logic [7:0] OFS_OUTPUT_PORT = 8'h28;
    localparam logic [7:0] OFS_EVENT_CLEAR = 8'h2C;

    // values after reset
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    localparam logic [7:0] RST_INT_VECTOR = 8'h0F;

    // interrupt pending bit positions
    localparam int IRQ_INPUT_CHANGE = 7;
    localparam int IRQ_BREAK_B = 6;
    localparam int IRQ_RX_B = 5;
    localparam int IRQ_TX_B = 4;
    localparam int IRQ_COUNTER = 3;
    localparam int IRQ_BREAK_A = 2;
    localparam int IRQ_RX_A = 1;
    localparam int IRQ_TX_A = 0;

    // auxiliary control fields
    localparam int AUX_BAUD_BIT = 7;
    localparam int AUX_CT_MODE_MSB = 6;
    localparam int AUX_CT_MODE_LSB = 4;

    // output pin 3 / pin 2 selector codes
    localparam logic [1:0] SEL_PORT_BIT = 2'h0;
    localparam logic [1:0] SEL_SRC_ONE = 2'h1;
    localparam logic [1:0] SEL_SRC_TWO = 2'h2;
    localparam logic [1:0] SEL_SRC_THREE = 2'h3;

    // ahb transfer type for a single transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // per-channel line flags, bit 7 first
    typedef struct packed {
        logic received_break;
        logic framing_error;
        logic parity_error;
        logic overrun_error;
        logic transmitter_empty;
        logic transmitter_ready;
        logic receive_fifo_full;
        logic receiver_ready;
    } line_flags_t;

    // clock sources that may be routed to output pins 3 and 2
    typedef struct packed {
        logic ct_output;
        logic tx_clk_b_1x;
        logic rx_clk_b_1x;
        logic tx_clk_a_16x;
        logic tx_clk_a_1x;
        logic rx_clk_a_1x;
    } pin_sources_t;

endpackage

//--- core/input_change_detect.sv
// change detector and level mirror for the four general inputs
`timescale 1ns/1ns
module input_change_detect (
    input wire logic i_core_clk,        // core clock
    input wire logic i_rst_n,           // synchronous reset, active low
    input wire logic [3:0] i_level,     // general inputs 3..0
    input wire logic i_clear,           // one-cycle pulse: clear change flags
    output logic [3:0] o_level,         // registered present level
    output logic [3:0] o_change         // sticky change flags
);

    logic armed_q;
    logic [3:0] level_q;
    logic [3:0] change_q;

    // first cycle after reset only loads the level, so a high input is no false change
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            armed_q <= 1'b0;
        else
            armed_q <= 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_bit
            // level mirror and sticky change flag; a new change beats a clear
            always_ff @(posedge i_core_clk)
            begin
                if (!i_rst_n)
                begin
                    level_q[g] <= 1'b0;
                    change_q[g] <= 1'b0;
                end
                else
                begin
                    level_q[g] <= i_level[g];
                    if (armed_q && (i_level[g] != level_q[g]))
                        change_q[g] <= 1'b1;
                    else if (i_clear)
                        change_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_level = level_q;
    assign o_change = change_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_change_caught: assert property (armed_q && (i_level[0] != level_q[0])
        |=> o_change[0])
        else $error("input change not flagged");
    a_level_mirror: assert property (armed_q |=> o_level == $past(i_level))
        else $error("level mirror wrong");

endmodule

//--- core/serial_status_regs.sv
// register bank for status, pin function, aux control and interrupt of a dual serial controller
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module serial_status_regs (
    input wire logic i_core_clk,                          // core clock, 10 MHz
    input wire logic i_rst_n,                             // synchronous reset, active low
    input wire logic i_hsel,                              // ahb slave select
    input wire logic [7:0] i_haddr,                       // ahb byte address, low bits
    input wire logic [1:0] i_htrans,                      // ahb transfer type
    input wire logic i_hwrite,                            // ahb write
    input wire logic [2:0] i_hsize,                       // ahb size, word only
    input wire logic [31:0] i_hwdata,                     // ahb write data
    input wire logic i_hready,                            // ahb bus ready
    output logic [31:0] o_hrdata,                         // ahb read data
    output logic o_hreadyout,                             // ahb slave ready
    output logic o_hresp,                                 // ahb response, always okay
    input wire serial_regs_pkg::line_flags_t i_flags_a,  // channel a line flags
    input wire serial_regs_pkg::line_flags_t i_flags_b,  // channel b line flags
    input wire logic i_break_change_a,                    // pulse: channel a break changed
    input wire logic i_break_change_b,                    // pulse: channel b break changed
    input wire logic i_rx_ready_full_a,                   // channel a rx ready or fifo full
    input wire logic i_rx_ready_full_b,                   // channel b rx ready or fifo full
    input wire logic i_counter_ready,                     // pulse: counter reached end
    input wire serial_regs_pkg::pin_sources_t i_pin_src,  // clocks routable to pins 3, 2
    input wire logic [3:0] i_general_in,                  // general inputs 3..0
    input wire logic i_int_ack,                           // pulse: interrupt acknowledge
    output logic [7:0] o_general_out,                     // general output pins 7..0
    output logic o_irq,                                   // interrupt request, active high
    output logic [7:0] o_vector,                          // vector during acknowledge
    output logic o_vector_valid,                          // pulse: vector valid
    output logic o_baud_table_choice,                     // 0 table set 1, 1 table set 2
    output logic [2:0] o_ct_mode,                         // counter mode and source
    output logic [15:0] o_ct_preset                       // counter preset value
);

    logic [7:0] status_a_q;
    logic [7:0] status_b_q;
    logic [7:0] pin_cfg_q;
    logic [7:0] aux_q;
    logic [7:0] mask_q;
    logic [7:0] ct_high_q;
    logic [7:0] ct_low_q;
    logic [7:0] vector_q;
    logic [7:0] port_q;
    logic break_a_q;
    logic break_b_q;
    logic counter_q;
    logic [7:0] pending;
    logic [3:0] in_level;
    logic [3:0] in_change;
    logic change_clear;
    logic [7:0] rdata_d;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic wr_en;
    logic rd_en;
    logic [7:0] gen_out_q;
    logic irq_q;
    logic [7:0] vec_out_q;
    logic vec_valid_q;
    logic [7:0] clr_bits;

    // address phase: a valid single transfer to this slave
    assign rd_en = i_hsel && i_hready && (i_htrans == serial_regs_pkg::HTRANS_NONSEQ)
        && !i_hwrite;
    assign wr_en = wr_pend_q;
    assign clr_bits = (wr_en && (wr_addr_q == serial_regs_pkg::OFS_EVENT_CLEAR))
        ? i_hwdata[7:0] : serial_regs_pkg::RST_ZERO8;
    // reading the input change register acknowledges its change flags
    assign change_clear = rd_en && (i_haddr == serial_regs_pkg::OFS_INPUT_CHANGE);

    input_change_detect u_change (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_general_in),
        .i_clear(change_clear),
        .o_level(in_level),
        .o_change(in_change)
    );

    // write address is held over to the data phase, where hwdata stands
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= serial_regs_pkg::RST_ZERO8;
        end
        else if (i_hready)
        begin
            wr_pend_q <= i_hsel && (i_htrans == serial_regs_pkg::HTRANS_NONSEQ) && i_hwrite;
            wr_addr_q <= i_haddr;
        end
    end

    // status mirrors of both channels; follow the flags every cycle, zero at reset
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            status_a_q <= serial_regs_pkg::RST_ZERO8;
            status_b_q <= serial_regs_pkg::RST_ZERO8;
        end
        else
        begin
            status_a_q <= i_flags_a;
            status_b_q <= i_flags_b;
        end
    end

    // software-written control registers
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            pin_cfg_q <= serial_regs_pkg::RST_ZERO8;
            mask_q <= serial_regs_pkg::RST_ZERO8;
            port_q <= serial_regs_pkg::RST_ZERO8;
            vector_q <= serial_regs_pkg::RST_INT_VECTOR;
            aux_q <= serial_regs_pkg::RST_ZERO8;
            ct_high_q <= serial_regs_pkg::RST_ZERO8;
            ct_low_q <= serial_regs_pkg::RST_ZERO8;
        end
        else if (wr_en)
        begin
            unique case (wr_addr_q)
                serial_regs_pkg::OFS_OUT_PIN_CFG: pin_cfg_q <= i_hwdata[7:0];
                serial_regs_pkg::OFS_AUX_CONTROL: aux_q <= i_hwdata[7:0];
                serial_regs_pkg::OFS_INT_MASK: mask_q <= i_hwdata[7:0];
                serial_regs_pkg::OFS_CT_PRESET_HIGH: ct_high_q <= i_hwdata[7:0];
                serial_regs_pkg::OFS_CT_PRESET_LOW: ct_low_q <= i_hwdata[7:0];
                serial_regs_pkg::OFS_INT_VECTOR: vector_q <= i_hwdata[7:0];
                serial_regs_pkg::OFS_OUTPUT_PORT: port_q <= i_hwdata[7:0];
                default: ;
            endcase
        end
    end

    // sticky event flags; a new event in the clearing cycle wins
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            break_a_q <= 1'b0;
            break_b_q <= 1'b0;
            counter_q <= 1'b0;
        end
        else
        begin
            break_a_q <= i_break_change_a
                || (break_a_q && !clr_bits[serial_regs_pkg::IRQ_BREAK_A]);
            break_b_q <= i_break_change_b
                || (break_b_q && !clr_bits[serial_regs_pkg::IRQ_BREAK_B]);
            counter_q <= i_counter_ready || (counter_q && !clr_bits[serial_regs_pkg::IRQ_COUNTER]);
        end
    end

    // pending flags: ready bits are live levels, input change is gated by aux enables
    always_comb
    begin
        pending = serial_regs_pkg::RST_ZERO8;
        pending[serial_regs_pkg::IRQ_INPUT_CHANGE] = |(in_change & aux_q[3:0]);
        pending[serial_regs_pkg::IRQ_BREAK_B] = break_b_q;
        pending[serial_regs_pkg::IRQ_RX_B] = i_rx_ready_full_b;
        pending[serial_regs_pkg::IRQ_TX_B] = i_flags_b.transmitter_ready;
        pending[serial_regs_pkg::IRQ_COUNTER] = counter_q;
        pending[serial_regs_pkg::IRQ_BREAK_A] = break_a_q;
        pending[serial_regs_pkg::IRQ_RX_A] = i_rx_ready_full_a;
        pending[serial_regs_pkg::IRQ_TX_A] = i_flags_a.transmitter_ready;
    end

    // read mux in the address phase, so read data stands for the whole data phase
    always_comb
    begin
        rdata_d = serial_regs_pkg::RST_ZERO8;
        unique case (i_haddr)
            serial_regs_pkg::OFS_LINE_STATUS_A: rdata_d = status_a_q;
            serial_regs_pkg::OFS_LINE_STATUS_B: rdata_d = status_b_q;
            serial_regs_pkg::OFS_OUT_PIN_CFG: rdata_d = pin_cfg_q;
            serial_regs_pkg::OFS_AUX_CONTROL: rdata_d = aux_q;
            serial_regs_pkg::OFS_INPUT_CHANGE: rdata_d = {in_change, in_level};
            serial_regs_pkg::OFS_INT_PENDING: rdata_d = pending;
            serial_regs_pkg::OFS_INT_MASK: rdata_d = mask_q;
            serial_regs_pkg::OFS_CT_PRESET_HIGH: rdata_d = ct_high_q;
            serial_regs_pkg::OFS_CT_PRESET_LOW: rdata_d = ct_low_q;
            serial_regs_pkg::OFS_INT_VECTOR: rdata_d = vector_q;
            serial_regs_pkg::OFS_OUTPUT_PORT: rdata_d = port_q;
            default: rdata_d = serial_regs_pkg::RST_ZERO8;
        endcase
    end

    // zero-wait slave: ready always high, unmapped reads return zero
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            hrdata_q <= 32'h00000000;
        else if (rd_en)
            hrdata_q <= {24'h000000, rdata_d};
    end

    // output pin functions, registered so the pins never glitch
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            gen_out_q <= serial_regs_pkg::RST_ZERO8;
        else
        begin
            gen_out_q[7] <= pin_cfg_q[7] ? i_flags_b.transmitter_ready : port_q[7];
            gen_out_q[6] <= pin_cfg_q[6] ? i_flags_a.transmitter_ready : port_q[6];
            gen_out_q[5] <= pin_cfg_q[5] ? i_rx_ready_full_b : port_q[5];
            gen_out_q[4] <= pin_cfg_q[4] ? i_rx_ready_full_a : port_q[4];
            unique case (pin_cfg_q[3:2])
                serial_regs_pkg::SEL_PORT_BIT: gen_out_q[3] <= port_q[3];
                serial_regs_pkg::SEL_SRC_ONE: gen_out_q[3] <= i_pin_src.ct_output;
                serial_regs_pkg::SEL_SRC_TWO: gen_out_q[3] <= i_pin_src.tx_clk_b_1x;
                serial_regs_pkg::SEL_SRC_THREE: gen_out_q[3] <= i_pin_src.rx_clk_b_1x;
            endcase
            unique case (pin_cfg_q[1:0])
                serial_regs_pkg::SEL_PORT_BIT: gen_out_q[2] <= port_q[2];
                serial_regs_pkg::SEL_SRC_ONE: gen_out_q[2] <= i_pin_src.tx_clk_a_16x;
                serial_regs_pkg::SEL_SRC_TWO: gen_out_q[2] <= i_pin_src.tx_clk_a_1x;
                serial_regs_pkg::SEL_SRC_THREE: gen_out_q[2] <= i_pin_src.rx_clk_a_1x;
            endcase
            gen_out_q[1:0] <= port_q[1:0];
        end
    end

    // interrupt request and vector answer; a level, so the host sees it until serviced
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            irq_q <= 1'b0;
            vec_out_q <= serial_regs_pkg::RST_ZERO8;
            vec_valid_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(pending & mask_q);
            vec_valid_q <= i_int_ack;
            if (i_int_ack)
                vec_out_q <= vector_q;
        end
    end

    assign o_hrdata = hrdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_general_out = gen_out_q;
    assign o_irq = irq_q;
    assign o_vector = vec_out_q;
    assign o_vector_valid = vec_valid_q;
    assign o_baud_table_choice = aux_q[serial_regs_pkg::AUX_BAUD_BIT];
    assign o_ct_mode = aux_q[serial_regs_pkg::AUX_CT_MODE_MSB:serial_regs_pkg::AUX_CT_MODE_LSB];
    assign o_ct_preset = {ct_high_q, ct_low_q};

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_status_mirror: assert property (##1 status_a_q == $past(i_flags_a))
        else $error("channel a status not mirrored");
    a_pin7_function: assert property (pin_cfg_q[7] && $stable(pin_cfg_q) ##1 pin_cfg_q[7]
        |-> o_general_out[7] == $past(i_flags_b.transmitter_ready))
        else $error("pin 7 does not carry tx ready b");
    a_pin3_select: assert property (pin_cfg_q[3:2] == 2'h1
        |=> o_general_out[3] == $past(i_pin_src.ct_output))
        else $error("pin 3 counter source wrong");
    a_aux_write: assert property (wr_en && wr_addr_q == serial_regs_pkg::OFS_AUX_CONTROL
        |=> o_baud_table_choice == $past(i_hwdata[7]) && o_ct_mode == $past(i_hwdata[6:4]))
        else $error("aux control write lost");
    a_break_sticky: assert property ($rose(i_break_change_a) |=> pending[2] [*2]
        or (pending[2] ##1 $past(clr_bits[2])))
        else $error("break a flag not held");
    a_irq_raise: assert property ((pending & mask_q) != 8'h00 |=> o_irq)
        else $error("interrupt not raised");
    a_irq_drop: assert property ((pending & mask_q) == 8'h00 |=> !o_irq)
        else $error("interrupt not released");
    a_preset_join: assert property (wr_en
        && wr_addr_q == serial_regs_pkg::OFS_CT_PRESET_HIGH
        |=> o_ct_preset[15:8] == $past(i_hwdata[7:0]))
        else $error("preset high byte wrong");
    a_preset_low: assert property (wr_en
        && wr_addr_q == serial_regs_pkg::OFS_CT_PRESET_LOW
        |=> o_ct_preset[7:0] == $past(i_hwdata[7:0]))
        else $error("preset low byte wrong");
    a_vector_answer: assert property (i_int_ack |=> o_vector_valid
        && o_vector == $past(vector_q))
        else $error("vector not supplied on acknowledge");
    a_reset_vector: assert property (disable iff (1'b0) !i_rst_n |=> vector_q == 8'h0F
        && mask_q == 8'h00 && port_q == 8'h00)
        else $error("reset values wrong");
    a_mask_gates: assert property (mask_q == 8'h00 |=> !o_irq)
        else $error("masked interrupt leaked");

    c_irq_seen: cover property ($rose(o_irq));
    c_vector_ack: cover property (i_int_ack ##1 o_vector_valid);
    c_input_change: cover property ($rose(pending[7]));
    c_pin_clock: cover property (pin_cfg_q[1:0] == 2'h3 ##1 o_general_out[2]);

endmodule

//--- bench/ahb_host_model.sv
// register bus master standing for the host processor
`timescale 1ns/1ns
module ahb_host_model (
    input wire logic i_core_clk,       // core clock
    input wire logic i_hready,         // bus ready
    input wire logic [31:0] i_hrdata,  // read data from the slave
    output logic o_hsel,               // slave select
    output logic [7:0] o_haddr,        // byte address
    output logic [1:0] o_htrans,       // transfer type
    output logic o_hwrite,             // write
    output logic [2:0] o_hsize,        // always one word
    output logic [31:0] o_hwdata       // write data
);
    // idle bus at time zero; unused write data is scrambled, never left at the last value
    initial
    begin
        o_hsel = 1'b0;
        o_haddr = 8'h00;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h5A5A_A5A5;
    end

    // bounded wait for ready at a rising edge
    task automatic wait_ready(inout logic ok);
        int n;
        n = 0;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end while (i_hready !== 1'b1 && n < 20);
        if (i_hready !== 1'b1)
            ok = 1'b0;
    endtask

    // one single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
        ok = 1'b1;
        @(posedge i_core_clk);
        o_hsel <= 1'b1;
        o_haddr <= addr;
        o_htrans <= serial_regs_pkg::HTRANS_NONSEQ;
        o_hwrite <= wr;
        wait_ready(ok);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= wr ? wdata : ~o_hwdata;
        wait_ready(ok);
        rdata = i_hrdata;
        o_hwdata <= ~o_hwdata;
    endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for the serial controller register bank
`timescale 1ns/1ns
`define CHECK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t: %h not %h", $time, got, exp); \
        end \
    end
module testbench;
    logic i_core_clk, i_rst_n, hsel, hwrite, hready, hresp, brk_a, brk_b, rxf_a, rxf_b, ctr;
    logic ack, irq, baud, vvalid;
    logic [7:0] haddr, gout, vec;
    logic [1:0] htrans;
    logic [2:0] hsize, ct_mode;
    logic [31:0] hwdata, hrdata;
    logic [5:0] src;
    logic [3:0] gin;
    logic [15:0] preset;
    serial_regs_pkg::line_flags_t fa, fb;
    int mismatches = 0;
    int cmp_count = 0;

    ahb_host_model host (.i_core_clk(i_core_clk), .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
        .o_hsize(hsize), .o_hwdata(hwdata));
    serial_status_regs DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_flags_a(fa), .i_flags_b(fb), .i_break_change_a(brk_a),
        .i_break_change_b(brk_b), .i_rx_ready_full_a(rxf_a), .i_rx_ready_full_b(rxf_b),
        .i_counter_ready(ctr), .i_pin_src(src), .i_general_in(gin), .i_int_ack(ack),
        .o_general_out(gout), .o_irq(irq), .o_vector(vec), .o_vector_valid(vvalid),
        .o_baud_table_choice(baud), .o_ct_mode(ct_mode), .o_ct_preset(preset));

    // 10 MHz core clock
    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // bus access; a hung transfer ends the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r);
        logic [31:0] rw;
        logic ok;
        host.xfer(w, a, {24'h0, d}, rw, ok);
        `CHECK({hresp, rw[31:8]}, 25'h0)
        r = rw[7:0];
        if (!ok)
        begin
            mismatches++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        xfer(1'b0, a, 8'h00, r);
        `CHECK(r, e)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    task automatic reset_dut();
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        cyc(0);
    endtask

    // mid-run reset after dirtying the mask, pin config, port and vector registers and the break a flag
    task automatic t_reset();
        wr(serial_regs_pkg::OFS_INT_MASK, 8'hFF);
        wr(serial_regs_pkg::OFS_OUT_PIN_CFG, 8'hF5);
        wr(serial_regs_pkg::OFS_OUTPUT_PORT, 8'hFF);
        wr(serial_regs_pkg::OFS_INT_VECTOR, 8'h33);
        drive_src(2, 1'b1);
        drive_src(2, 1'b0);
        reset_dut();
        `CHECK(gout, 8'h00)
        rd(serial_regs_pkg::OFS_INT_VECTOR, serial_regs_pkg::RST_INT_VECTOR);
        rd(serial_regs_pkg::OFS_INT_MASK, 8'h00);
        rd(serial_regs_pkg::OFS_OUT_PIN_CFG, 8'h00);
        rd(serial_regs_pkg::OFS_INT_PENDING, 8'h00);
        rd(serial_regs_pkg::OFS_LINE_STATUS_A, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset done");
    endtask

    // complementary flag patterns on the two channels
    task automatic t_status();
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_core_clk);
            fa <= k ? 8'h5A : 8'hA5;
            fb <= k ? 8'hA5 : 8'h5A;
            cyc(2);
            rd(serial_regs_pkg::OFS_LINE_STATUS_A, k ? 8'h5A : 8'hA5);
            rd(serial_regs_pkg::OFS_LINE_STATUS_B, k ? 8'hA5 : 8'h5A);
        end
        @(posedge i_core_clk);
        fa <= 8'h00;
        fb <= 8'h00;
        $display("test status done");
    endtask

    // every selector code with two source patterns, ready signals routed or not
    task automatic t_pins();
        logic [7:0] cfg, port, e;
        @(posedge i_core_clk);
        fa.transmitter_ready <= 1'b1;
        rxf_b <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            port = k ? 8'h5A : 8'hA5;
            wr(serial_regs_pkg::OFS_OUTPUT_PORT, port);
            @(posedge i_core_clk);
            src <= k ? 6'h16 : 6'h29;
            for (int c = 0; c < 4; c++)
            begin
                cfg = {k ? 4'h0 : 4'hF, c[1:0], c[1:0]};
                wr(serial_regs_pkg::OFS_OUT_PIN_CFG, cfg);
                cyc(2);
                e = port;
                if (cfg[7])
                    e[7:4] = 4'b0110;
                if (c != 0)
                    e[3:2] = {src[6 - c], src[3 - c]};
                `CHECK(gout, e)
                rd(serial_regs_pkg::OFS_OUT_PIN_CFG, cfg);
            end
        end
        @(posedge i_core_clk);
        fa <= 8'h00;
        rxf_b <= 1'b0;
        $display("test pins done");
    endtask

    // aux fields, counter preset bytes, vector on acknowledge
    task automatic t_fields();
        for (int k = 0; k < 2; k++)
        begin
            wr(serial_regs_pkg::OFS_AUX_CONTROL, k ? 8'h2A : 8'hD5);
            cyc(1);
            `CHECK({baud, ct_mode}, k ? 4'h2 : 4'hD)
            rd(serial_regs_pkg::OFS_AUX_CONTROL, k ? 8'h2A : 8'hD5);
        end
        wr(serial_regs_pkg::OFS_CT_PRESET_HIGH, 8'hA7);
        wr(serial_regs_pkg::OFS_CT_PRESET_LOW, 8'h3C);
        cyc(1);
        `CHECK(preset, 16'hA73C)
        rd(serial_regs_pkg::OFS_CT_PRESET_HIGH, 8'hA7);
        wr(serial_regs_pkg::OFS_INT_VECTOR, 8'h6E);
        @(posedge i_core_clk);
        ack <= 1'b1;
        @(posedge i_core_clk);
        ack <= 1'b0;
        cyc(0);
        `CHECK({vvalid, vec}, 9'h16E)
        cyc(1);
        `CHECK(vvalid, 1'b0)
        $display("test fields done");
    endtask

    // enabled and disabled input changes, flags cleared by reading
    task automatic t_inputs();
        wr(serial_regs_pkg::OFS_AUX_CONTROL, 8'h04);
        wr(serial_regs_pkg::OFS_INT_MASK, 8'h80);
        rd(serial_regs_pkg::OFS_INPUT_CHANGE, 8'h00);
        @(posedge i_core_clk);
        gin <= 4'h4;
        cyc(3);
        `CHECK(irq, 1'b1)
        rd(serial_regs_pkg::OFS_INT_PENDING, 8'h80);
        rd(serial_regs_pkg::OFS_INPUT_CHANGE, 8'h44);
        rd(serial_regs_pkg::OFS_INPUT_CHANGE, 8'h04);
        cyc(2);
        `CHECK(irq, 1'b0)
        @(posedge i_core_clk);
        gin <= 4'h5;
        cyc(3);
        `CHECK(irq, 1'b0)
        rd(serial_regs_pkg::OFS_INPUT_CHANGE, 8'h15);
        $display("test inputs done");
    endtask

    task automatic drive_src(input int i, input logic v);
        @(posedge i_core_clk);
        case (i)
            0: fa.transmitter_ready <= v;
            1: rxf_a <= v;
            2: brk_a <= v;
            3: ctr <= v;
            4: fb.transmitter_ready <= v;
            5: rxf_b <= v;
            default: brk_b <= v;
        endcase
    endtask

    // each pending source except input change alone, masked off, masked on, then cleared
    task automatic t_irq();
        bit pulse;
        for (int i = 0; i < 7; i++)
        begin
            pulse = (i == 2 || i == 3 || i == 6);
            wr(serial_regs_pkg::OFS_INT_MASK, 8'h00);
            drive_src(i, 1'b1);
            if (pulse)
                drive_src(i, 1'b0);
            cyc(2);
            `CHECK(irq, 1'b0)
            rd(serial_regs_pkg::OFS_INT_PENDING, 8'h01 << i);
            wr(serial_regs_pkg::OFS_INT_MASK, 8'h01 << i);
            cyc(1);
            `CHECK(irq, 1'b1)
            wr(serial_regs_pkg::OFS_INT_MASK, ~(8'h01 << i));
            cyc(1);
            `CHECK(irq, 1'b0)
            rd(serial_regs_pkg::OFS_INT_MASK, ~(8'h01 << i));
            if (pulse)
                wr(serial_regs_pkg::OFS_EVENT_CLEAR, 8'h01 << i);
            else
                drive_src(i, 1'b0);
            cyc(2);
            rd(serial_regs_pkg::OFS_INT_PENDING, 8'h00);
        end
        $display("test irq done");
    endtask

    // inputs at time zero, then the scenarios in turn
    initial
    begin
        {i_rst_n, brk_a, brk_b, rxf_a, rxf_b, ctr, ack} = 7'h00;
        {fa, fb, src, gin} = 26'h0;
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_status();
        t_pins();
        t_fields();
        t_inputs();
        t_irq();
        stop_test();
    end
endmodule
